// >>> verilog/nimhcs_charge_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - comparator mode toggles charge drive on/off at upper and lower sense thresholds.
// - band averages -0.107 V in bulk, -0.029 V in finishing phase.
// - conditioning phase limited to fixed 30 minutes; expiry enters fault.
// - rate-of-rise over threshold per minute ends bulk and starts finishing.
// - bulk safety timer expiry clears timer and moves to finishing phase.
// - finishing timeout is half bulk timeout, quarter on alternate variant.
// - finishing timer expiry ends charging into completed state.
// - bulk timeout 0.5 to 6 hours, 1.5 minutes per 1000 ohms.
// - start charging only while thermistor ratio between 0.73 and 0.33.
// - stop ratio 0.29 during conditioning gives fault.
// - stop ratio during bulk or finishing gives completed state.
// - floating timeout pin suspends and resets the state machine.
// - drive low turns pass element on; open turns it off.
// - ignore rate of rise for 4.3 minutes after bulk start.
// - cell not above 1.0 V by conditioning timeout gives fault.
// - fault held until cell above 1.65 V, then presence test.
module nimhcs_charge_sequencer #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int unsigned TICK_CYCLES_P = nimhcs_pkg::TICK_CYCLES,
    parameter int unsigned TICKS_PER_MIN_P = nimhcs_pkg::TICKS_PER_MIN
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic comparator_mode_in,
    input wire logic sense_above_upper_in,
    input wire logic sense_below_lower_in,
    input wire logic linear_drive_in,
    input wire logic timeout_set_pin_float_in,
    input wire logic [8:0] timeout_set_kohm_in,
    input wire logic temp_below_low_ratio_in,
    input wire logic temp_above_high_ratio_in,
    input wire logic temp_at_stop_ratio_in,
    input wire logic temp_rise_over_rate_in,
    input wire logic cell_above_low_in,
    input wire logic cell_open_in,
    output logic charge_drive_out,
    output logic charge_drive_oen_out,
    output logic bulk_select_out,
    output logic [2:0] state_out,
    output logic done_out,
    output logic fault_out
);
    import nimhcs_pkg::*;

    localparam logic [TMR_W-1:0] TICK_LAST = TMR_W'(TICK_CYCLES_P - 1);
    localparam logic [TMR_W-1:0] MIN_TICKS = TMR_W'(TICKS_PER_MIN_P);
    localparam logic [TMR_W-1:0] COND_LIMIT = TMR_W'(COND_TIMEOUT_MIN * TICKS_PER_MIN_P);
    localparam logic [TMR_W-1:0] BLANK_LIMIT =
        TMR_W'((BLANK_TENTHS_MIN * TICKS_PER_MIN_P) / 10);

    nimhcs_state_type state_q, state_d;
    logic [TMR_W-1:0] div_q;
    logic [TMR_W-1:0] phase_q;
    logic [TMR_W-1:0] rate_q;
    logic drive_on_q;
    logic oen_q;
    logic done_q, fault_q, bulk_q;

    wire tick = (div_q == TICK_LAST);
    // bulk limit: kohm * 1.5 minutes, clamped 0.5..6 hours
    wire [TMR_W-1:0] kohm_tenths = TMR_W'(timeout_set_kohm_in) * TMR_W'(BULK_TENTHS_PER_KOHM);
    wire [TMR_W-1:0] bulk_raw_min = kohm_tenths / TMR_W'(10);
    wire [TMR_W-1:0] bulk_min = (bulk_raw_min < TMR_W'(BULK_MIN_MIN)) ? TMR_W'(BULK_MIN_MIN) :
        (bulk_raw_min > TMR_W'(BULK_MAX_MIN)) ? TMR_W'(BULK_MAX_MIN) : bulk_raw_min;
    wire [TMR_W-1:0] bulk_limit = bulk_min * MIN_TICKS;
    // finishing limit half or quarter of bulk
    wire [TMR_W-1:0] finish_limit = ALT_VARIANT ? (bulk_limit >> 2) : (bulk_limit >> 1);
    wire phase_expired_cond = tick && (phase_q >= COND_LIMIT - TMR_W'(1));
    wire phase_expired_bulk = tick && (phase_q >= bulk_limit - TMR_W'(1));
    wire phase_expired_fin = tick && (phase_q >= finish_limit - TMR_W'(1));
    wire blank_over = (phase_q >= BLANK_LIMIT);
    // rate flag evaluated once per minute window after blanking
    wire rate_window_end = tick && (rate_q >= MIN_TICKS - TMR_W'(1));
    wire rate_trip = blank_over && rate_window_end && temp_rise_over_rate_in;
    wire temp_ok = !temp_below_low_ratio_in && !temp_above_high_ratio_in;
    wire charging = (state_q == NIMHCS_COND) || (state_q == NIMHCS_BULK) ||
        (state_q == NIMHCS_FINISH);
    wire phase_change = (state_d != state_q);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            NIMHCS_PRESENCE:
                if (!cell_open_in && temp_ok)
                    state_d = NIMHCS_COND;
            NIMHCS_COND:
                if (cell_open_in)
                    state_d = NIMHCS_PRESENCE;
                else if (temp_at_stop_ratio_in)
                    state_d = NIMHCS_FAULT;
                else if (cell_above_low_in)
                    state_d = NIMHCS_BULK;
                else if (phase_expired_cond)
                    state_d = NIMHCS_FAULT;
            NIMHCS_BULK:
                if (cell_open_in)
                    state_d = NIMHCS_PRESENCE;
                else if (temp_at_stop_ratio_in)
                    state_d = NIMHCS_DONE;
                else if (rate_trip || phase_expired_bulk)
                    state_d = NIMHCS_FINISH;
            NIMHCS_FINISH:
                if (cell_open_in)
                    state_d = NIMHCS_PRESENCE;
                else if (temp_at_stop_ratio_in || phase_expired_fin)
                    state_d = NIMHCS_DONE;
            NIMHCS_DONE:
                if (cell_open_in)
                    state_d = NIMHCS_PRESENCE;
            NIMHCS_FAULT:
                if (cell_open_in)
                    state_d = NIMHCS_PRESENCE;
            default:
                state_d = NIMHCS_PRESENCE;
        endcase
        if (timeout_set_pin_float_in)
            state_d = NIMHCS_PRESENCE;
    end

    // comparator hysteresis: on below lower, off above upper
    wire drive_on_d = !charging ? 1'b0 :
        !comparator_mode_in ? linear_drive_in :
        sense_above_upper_in ? 1'b0 :
        sense_below_lower_in ? 1'b1 : drive_on_q;
    // drive forced off on the cycle a phase changes or suspend starts
    wire drive_next = drive_on_d && !phase_change && !timeout_set_pin_float_in;
    wire timers_clear = phase_change || timeout_set_pin_float_in;
    // tick divider free-runs, restarted by suspend
    wire [TMR_W-1:0] div_d = (tick || timeout_set_pin_float_in) ? TMR_RESET :
        div_q + TMR_W'(1);
    // phase timer restarts on every phase entry
    wire [TMR_W-1:0] phase_d = timers_clear ? TMR_RESET :
        tick ? phase_q + TMR_W'(1) : phase_q;
    // rate window restarts each minute and on phase entry
    wire [TMR_W-1:0] rate_d = (timers_clear || rate_window_end) ? TMR_RESET :
        tick ? rate_q + TMR_W'(1) : rate_q;
    // state flags taken from next state to line up with state_out
    wire done_d = (state_d == NIMHCS_DONE);
    wire fault_d = (state_d == NIMHCS_FAULT);
    wire bulk_d = (state_d == NIMHCS_BULK);

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            state_q <= NIMHCS_PRESENCE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            div_q <= TMR_RESET;
        else
            div_q <= div_d;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            phase_q <= TMR_RESET;
        else
            phase_q <= phase_d;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rate_q <= TMR_RESET;
        else
            rate_q <= rate_d;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            drive_on_q <= 1'b0;
        else
            drive_on_q <= drive_next;
    end

    // enable low pulls the pin low, pass element on
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            oen_q <= 1'b1;
        else
            oen_q <= !drive_next;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            done_q <= 1'b0;
        else
            done_q <= done_d;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            fault_q <= 1'b0;
        else
            fault_q <= fault_d;
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            bulk_q <= 1'b0;
        else
            bulk_q <= bulk_d;
    end

    // open-drain data bit; only the enable moves the pin
    assign charge_drive_out = 1'b0;
    assign charge_drive_oen_out = oen_q;
    assign bulk_select_out = bulk_q;
    assign state_out = state_q;
    assign done_out = done_q;
    assign fault_out = fault_q;

endmodule
`default_nettype wire

// >>> verilog/nimhcs_pkg.sv
package nimhcs_pkg;

    // states, gray along presence->cond->bulk->finish->done
    typedef enum logic [2:0] {
        NIMHCS_PRESENCE = 3'b000,
        NIMHCS_COND     = 3'b001,
        NIMHCS_BULK     = 3'b011,
        NIMHCS_FINISH   = 3'b010,
        NIMHCS_DONE     = 3'b110,
        NIMHCS_FAULT    = 3'b111
    } nimhcs_state_type;

    localparam int unsigned CLK_HZ = 100_000_000;
    // oscillator tick period for all phase timers
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TICKS_PER_MIN = 60_000;
    // conditioning limit in minutes
    localparam int unsigned COND_TIMEOUT_MIN = 30;
    // blanking in tenths of a minute (4.3 min)
    localparam int unsigned BLANK_TENTHS_MIN = 43;
    // bulk timeout scaling: 1.5 min per 1000 ohm, in tenths of minutes
    localparam int unsigned BULK_TENTHS_PER_KOHM = 15;
    localparam int unsigned BULK_MIN_MIN = 30;
    localparam int unsigned BULK_MAX_MIN = 360;
    // sense targets in millivolts (average of comparator band)
    localparam int BULK_SENSE_TARGET_MV = -107;
    localparam int FINISH_SENSE_TARGET_MV = -29;
    // thermistor ratio thresholds in thousandths
    localparam int unsigned TEMP_WINDOW_LOW_RATIO = 730;
    localparam int unsigned TEMP_WINDOW_HIGH_RATIO = 330;
    localparam int unsigned TEMP_STOP_RATIO = 290;
    localparam int unsigned LOW_CELL_MV = 1000;
    localparam int unsigned OPEN_CELL_MV = 1650;
    localparam int unsigned TMR_W = 32;
    localparam logic [TMR_W-1:0] TMR_RESET = 32'h0000_0000;

endpackage

// >>> dv/nimhcs_charge_sequencer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module nimhcs_charge_sequencer_asserts (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic comparator_mode_in,
    input wire logic sense_above_upper_in,
    input wire logic sense_below_lower_in,
    input wire logic timeout_set_pin_float_in,
    input wire logic temp_at_stop_ratio_in,
    input wire logic cell_above_low_in,
    input wire logic cell_open_in,
    input wire logic charge_drive_out,
    input wire logic charge_drive_oen_out,
    input wire logic done_out,
    input wire logic bulk_select_out,
    input wire logic [2:0] state_out,
    input wire logic fault_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    wire logic go = !timeout_set_pin_float_in && !cell_open_in;
    wire logic chg = state_out inside {3'h1, 3'h3, 3'h2};
    suspend_reset_a:
    assert property (timeout_set_pin_float_in |=> state_out == 3'h0) else $error("no reset");
    idle_off_a:
    assert property (state_out[2] |-> charge_drive_oen_out) else $error("drive on idle");
    flag_map_a:
    assert property (bulk_select_out == (state_out == 3'h3) && fault_out == &state_out)
        else $error("flag mismatch");
    cond_stop_a:
    assert property (state_out == 3'h1 && temp_at_stop_ratio_in && go && !cell_above_low_in
        |=> state_out == 3'h7) else $error("no fault on stop");
    chg_stop_a:
    assert property (state_out[1] && !state_out[2] && temp_at_stop_ratio_in && go
        |=> state_out == 3'h6) else $error("no done on stop");
    cond_adv_a:
    assert property (state_out == 3'h1 && cell_above_low_in && !temp_at_stop_ratio_in && go
        |=> state_out == 3'h3) else $error("no bulk");
    fault_exit_a:
    assert property (fault_out && cell_open_in |=> state_out == 3'h0)
        else $error("fault held");
    fault_hold_a:
    assert property (fault_out && go |=> fault_out) else $error("fault left early");
    comp_off_a:
    assert property (comparator_mode_in && chg && sense_above_upper_in && !sense_below_lower_in
        |=> charge_drive_oen_out) else $error("drive not off");
    comp_on_a:
    assert property (comparator_mode_in && chg && sense_below_lower_in && !sense_above_upper_in
        |=> !charge_drive_oen_out || state_out != $past(state_out))
        else $error("drive not on");
    done_map_a:
    assert property (done_out == (state_out == 3'h6)) else $error("done flag mismatch");
    drive_low_a:
    assert property (!charge_drive_out) else $error("drive data not low");
    cover property (state_out == 3'h3 ##1 state_out == 3'h2);
    cover property (state_out == 3'h2 ##1 state_out == 3'h6);
    cover property (state_out == 3'h1 ##1 state_out == 3'h7);
endmodule
`default_nettype wire

// >>> dv/nimhcs_sense_model.sv
`timescale 1ns/10ps
`default_nettype none
module nimhcs_sense_model (
    input wire logic ref_clk_in,
    input wire logic charge_drive_oen_in,
    output logic above_out,
    output logic below_out
);
    int level = 0;
    // current ramps up only while the pass element is pulled on
    always @(posedge ref_clk_in)
        level <= #1 charge_drive_oen_in ? (level > 0 ? level - 1 : 0) :
            (level < 8 ? level + 1 : 8);
    assign above_out = level >= 4;
    assign below_out = level <= 0;
endmodule
`default_nettype wire

// >>> dv/tb_nimh_charge_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_nimh_charge_sequencer;
    localparam int MC = 20;
    logic ref_clk_in = 0, resetn_in = 0, cmode = 1, lin = 0, flt = 0, cold = 0, hot = 0;
    logic stop = 0, rise = 0, low_ok = 0, open_c = 0, above, below, oen;
    logic [8:0] kohm = 9'h000;
    logic [2:0] st, st_alt;
    int num_errors = 0, checked = 0, n, seed = 32'hDC714DCD;
    nimhcs_charge_sequencer #(.TICK_CYCLES_P(2), .TICKS_PER_MIN_P(10)) dut_u (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .comparator_mode_in(cmode),
        .sense_above_upper_in(above), .sense_below_lower_in(below), .linear_drive_in(lin),
        .timeout_set_pin_float_in(flt), .timeout_set_kohm_in(kohm),
        .temp_below_low_ratio_in(cold), .temp_above_high_ratio_in(hot),
        .temp_at_stop_ratio_in(stop), .temp_rise_over_rate_in(rise),
        .cell_above_low_in(low_ok), .cell_open_in(open_c), .charge_drive_out(),
        .charge_drive_oen_out(oen), .bulk_select_out(), .state_out(st), .done_out(),
        .fault_out());
    nimhcs_charge_sequencer #(.ALT_VARIANT(1'b1), .TICK_CYCLES_P(2), .TICKS_PER_MIN_P(10))
    dut_alt_u (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .comparator_mode_in(cmode),
        .sense_above_upper_in(above), .sense_below_lower_in(below), .linear_drive_in(lin),
        .timeout_set_pin_float_in(flt), .timeout_set_kohm_in(kohm),
        .temp_below_low_ratio_in(cold), .temp_above_high_ratio_in(hot),
        .temp_at_stop_ratio_in(stop), .temp_rise_over_rate_in(rise),
        .cell_above_low_in(low_ok), .cell_open_in(open_c), .charge_drive_out(),
        .charge_drive_oen_out(), .bulk_select_out(), .state_out(st_alt), .done_out(),
        .fault_out());
    nimhcs_sense_model pm_u (.ref_clk_in(ref_clk_in), .charge_drive_oen_in(oen),
        .above_out(above), .below_out(below));
    always #5 ref_clk_in = ~ref_clk_in;
    function automatic int bulk_cyc(input int k);
        int m;
        m = k * 15 / 10;
        return (m < 30 ? 30 : (m > 360 ? 360 : m)) * MC;
    endfunction
    task automatic test_done();
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wst(input logic [2:0] s, input int lo, input int hi);
        for (n = 0; n < hi && st !== s; n++)
            @(posedge ref_clk_in) #1;
        checked++;
        if (st !== s || n < lo)
        begin
            num_errors++;
            $display("[FAIL] %0t state %h after %0d, want %h", $time, st, n, s);
            if (st !== s)
                test_done();
        end
    endtask
    task automatic chk_alt(input logic [2:0] s);
        checked++;
        if (st_alt !== s)
        begin
            num_errors++;
            $display("[FAIL] %0t alt state %h, want %h", $time, st_alt, s);
        end
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        #1 resetn_in = 1;
        for (int i = 1; i < 3; i++)
        begin
            {cold, hot} = 2'(i);
            repeat (20) @(posedge ref_clk_in) #1;
            wst(3'h0, 0, 0);
        end
        {cold, hot} = 2'h0;
        wst(3'h1, 0, 3);
        wst(3'h7, 30 * MC - 3, 30 * MC + 3);
        open_c = 1;
        wst(3'h0, 0, 2);
        open_c = 0;
        wst(3'h1, 0, 3);
        stop = 1;
        wst(3'h7, 0, 2);
        {stop, open_c} = 2'h1;
        wst(3'h0, 0, 2);
        open_c = 0;
        for (int i = 0; i < 2; i++)
        begin
            wst(3'h1, 0, 3);
            kohm = 9'($unsigned($random(seed)) % 320);
            {cmode, lin} = {i == 0, 1'($random(seed))};
            low_ok = 1;
            wst(3'h3, 0, 3);
            wst(3'h2, bulk_cyc(kohm) - 3, bulk_cyc(kohm) + 3);
            repeat (bulk_cyc(kohm) / 4 - 3) @(posedge ref_clk_in) #1;
            chk_alt(3'h2);
            repeat (6) @(posedge ref_clk_in) #1;
            chk_alt(3'h6);
            wst(3'h6, bulk_cyc(kohm) / 4 - 6, bulk_cyc(kohm) / 4);
            {flt, low_ok} = 2'h2;
            wst(3'h0, 0, 2);
            flt = 0;
        end
        cmode = 1;
        low_ok = 1;
        wst(3'h3, 0, 6);
        rise = 1;
        wst(3'h2, 43 * MC / 10, 43 * MC / 10 + MC + 3);
        stop = 1;
        wst(3'h6, 0, 2);
        test_done();
    end
endmodule
bind nimhcs_charge_sequencer nimhcs_charge_sequencer_asserts chk_u (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .comparator_mode_in(comparator_mode_in),
    .sense_above_upper_in(sense_above_upper_in), .sense_below_lower_in(sense_below_lower_in),
    .timeout_set_pin_float_in(timeout_set_pin_float_in),
    .temp_at_stop_ratio_in(temp_at_stop_ratio_in), .cell_above_low_in(cell_above_low_in),
    .cell_open_in(cell_open_in), .charge_drive_oen_out(charge_drive_oen_out),
    .bulk_select_out(bulk_select_out), .state_out(state_out), .fault_out(fault_out),
    .done_out(done_out), .charge_drive_out(charge_drive_out));
`default_nettype wire
